// file: logic/ssfr_cfg.svh
// constants for the safety output resolution and overcurrent recovery block
`ifndef SSFR_CFG_SVH
`define SSFR_CFG_SVH

// ------------------------------------------------------------
// timing: 10 MHz clock, 1000 us recovery and flash tick
// ------------------------------------------------------------
`define SSFR_CLK_KHZ   32'h0000_2710
`define SSFR_TICK_US   32'h0000_03E8
`define SSFR_US_PER_MS 32'h0000_03E8
`define SSFR_TICK_CYC  ((`SSFR_CLK_KHZ * `SSFR_TICK_US) / `SSFR_US_PER_MS)

// ------------------------------------------------------------
// state table sizing
// ------------------------------------------------------------
`define SSFR_NSTATE 32'h20
`define SSFR_SW     32'h5
`define SSFR_DEPTH  32'h3

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define SSFR_AW       32'hC
`define SSFR_REG_CTRL 12'h000
`define SSFR_REG_STAT 12'h004
`define SSFR_REG_OCM  12'h008
`define SSFR_REG_DFLT 12'h00C
`define SSFR_REG_PASS 12'h010
`define SSFR_REG_FINT 12'h014
`define SSFR_REG_OUTS 12'h018
`define SSFR_REC_BASE 12'h040
`define SSFR_REC_MASK 12'h03F
`define SSFR_TAB_BASE 12'h100
`define SSFR_TAB_MASK 12'h0FF
`define SSFR_WSH      32'h2
`define SSFR_ESH      32'h3

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SSFR_CTRL_RUN  32'h0
`define SSFR_CTRL_INIT 32'h8
`define SSFR_STAT_FS   32'h0
`define SSFR_STAT_SUP  32'h1
`define SSFR_STAT_LNK  32'h2
`define SSFR_STAT_ACT  32'h3
`define SSFR_STAT_CUR  32'h8
`define SSFR_STAT_FLT  32'h10

`endif

// file: logic/ssfr_pkg.sv
// types shared by the safety output recovery block
package ssfr_pkg;
`include "ssfr_cfg.svh"

	// overcurrent response per channel
	typedef enum logic [1:0] {
		SSFR_OC_FAILSAFE,
		SSFR_OC_AUTO,
		SSFR_OC_NOREC,
		SSFR_OC_RSVD
	} ssfr_ocm_t;

	// output value keywords
	typedef enum logic [1:0] {
		SSFR_KW_FALSE,
		SSFR_KW_TRUE,
		SSFR_KW_FLASH,
		SSFR_KW_PASS
	} ssfr_kw_t;

	// channel trip state
	typedef enum logic {SSFR_CH_OK, SSFR_CH_TRIP} ssfr_chs_t;

	// one state table entry, low bits of its structure word
	typedef struct packed {
		logic                 cmp;
		logic                 par_en;
		logic [`SSFR_SW-1:0]  parent;
		logic [`SSFR_SW-1:0]  child;
		logic                 tr_en;
		logic [3:0]           cond;
		logic [`SSFR_SW-1:0]  target;
	} ssfr_ent_t;

	// wishbone request from the master
	typedef struct packed {
		logic                 cyc;
		logic                 stb;
		logic                 we;
		logic [`SSFR_AW-1:0]  adr;
		logic [3:0]           sel;
		logic [31:0]          dat;
	} ssfr_wb_req_t;
endpackage

// file: logic/ssfr_tick.sv
// tick divider and flash phase generator
`timescale 1ns/10ps
`include "ssfr_cfg.svh"
module ssfr_tick #(
	parameter int TICK_CYC = `SSFR_TICK_CYC,
	parameter int FW       = 16
) (
	// clock and reset
	input  logic          clk_i,
	input  logic          rst_i,
	// flash interval in ticks minus one
	input  logic [FW-1:0] fint_i,
	// enables
	output logic          tick_o,
	output logic          flash_o
);
	localparam int PW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

	if (TICK_CYC < 1 || FW < 1) begin : g_chk
		$error("ssfr_tick: bad parameters");
	end

	typedef struct packed {
		logic [PW-1:0] pre;
		logic          tick;
		logic [FW-1:0] fc;
		logic          ph;
	} ssfr_tk_t;
	ssfr_tk_t q, d;

	// prescaler, then flash phase toggled every fint_i+1 ticks
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.pre == PW'(TICK_CYC - 1)) begin
			d.pre = '0;
			d.tick = 1'b1;
		end else begin
			d.pre = q.pre + 1'b1;
		end
		if (q.tick) begin
			if (q.fc >= fint_i) begin
				d.fc = '0;
				d.ph = ~q.ph; // see RQ19
			end else begin
				d.fc = q.fc + 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) q <= '0;
		else q <= d;
	end

	assign tick_o = q.tick;
	assign flash_o = q.ph;

	property p_flash;
		@(posedge clk_i) disable iff (rst_i)
		$changed(flash_o) |-> $past(tick_o);
	endproperty
	a_flash: assert property (p_flash) // see RQ19
		else $error("flash phase moved without a tick");
endmodule

// file: logic/ssfr_chan.sv
// per-channel overcurrent trip and recovery timer
`timescale 1ns/10ps
`include "ssfr_cfg.svh"
module ssfr_chan #(
	parameter int RW = 16
) (
	// clock and reset
	input  logic                clk_i,
	input  logic                rst_i,
	// channel inputs
	input  logic                tick_i,
	input  logic                oc_i,
	input  logic                sup_ok_i,
	input  ssfr_pkg::ssfr_ocm_t mode_i,
	input  logic [RW-1:0]       rec_i,
	// channel outputs
	output logic                fault_o,
	output logic                deen_o,
	output logic                fs_o
);
	if (RW < 1) begin : g_chk
		$error("ssfr_chan: RW must be at least 1");
	end

	typedef struct packed {
		ssfr_pkg::ssfr_chs_t st;
		logic                fs;
		logic [RW-1:0]       cnt;
	} ssfr_chq_t;
	ssfr_chq_t q, d;

	// trip on overcurrent, count down only in auto recovery
	always_comb begin
		d = q;
		if (!sup_ok_i) begin
			d = '0; // see RQ2
		end else begin
			unique case (q.st)
			ssfr_pkg::SSFR_CH_OK: begin
				if (oc_i) begin
					d.st = ssfr_pkg::SSFR_CH_TRIP; // see RQ1
					d.cnt = rec_i; // see RQ20
					if (mode_i == ssfr_pkg::SSFR_OC_FAILSAFE) d.fs = 1'b1;
				end
			end
			ssfr_pkg::SSFR_CH_TRIP: begin
				if (mode_i == ssfr_pkg::SSFR_OC_AUTO && tick_i) begin
					if (q.cnt == '0) d.st = ssfr_pkg::SSFR_CH_OK; // see RQ3
					else d.cnt = q.cnt - 1'b1; // see RQ20
				end
			end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) q <= '0;
		else q <= d;
	end

	assign fault_o = (q.st == ssfr_pkg::SSFR_CH_TRIP);
	assign deen_o = fault_o | q.fs;
	assign fs_o = q.fs;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_trip;
		sup_ok_i && !fault_o && oc_i |=> fault_o && deen_o;
	endproperty
	a_trip: assert property (p_trip) // see RQ1
		else $error("overcurrent did not trip the channel");
	property p_fs_hold;
		fs_o && sup_ok_i |=> fs_o;
	endproperty
	a_fs_hold: assert property (p_fs_hold) // see RQ2
		else $error("fail-safe released without supply cycle");
	property p_norec;
		fault_o && sup_ok_i && mode_i != ssfr_pkg::SSFR_OC_AUTO |=> fault_o;
	endproperty
	a_norec: assert property (p_norec) // see RQ5
		else $error("latched fault cleared without supply cycle");
	property p_load;
		sup_ok_i && !fault_o && oc_i |=> q.cnt == $past(rec_i);
	endproperty
	a_load: assert property (p_load) // see RQ20
		else $error("recovery count not loaded on trip");
	property p_clear;
		sup_ok_i && fault_o && mode_i == ssfr_pkg::SSFR_OC_AUTO && tick_i
			&& q.cnt == '0 |=> !fault_o;
	endproperty
	a_clear: assert property (p_clear) // see RQ3
		else $error("auto recovery did not clear the fault");
	c_retrip: cover property ($fell(fault_o) ##[1:8] $rose(fault_o));
endmodule

// file: logic/ssfr_top.sv
// top of the safety output resolution and overcurrent recovery block
// Contract
// RQ1: overcurrent on a channel de-energizes it and raises its fault flag.
// RQ2: fail-safe option puts the module in fail-safe until supply cycles.
// RQ3: auto option clears the fault after the recovery time.
// RQ4: auto option trips again while overcurrent persists, repeating.
// RQ5: no-recover option keeps the channel off until supply cycles.
// RQ6: no-recover fault stays readable as a transition condition.
// RQ7: outputs and variables take their defaults when execution starts.
// RQ8: an output the active state leaves unassigned takes its default.
// RQ9: a compound state's defaults apply to the outputs they name.
// RQ10: inside a compound, unassigned outputs take the compound default.
// RQ11: a passthrough output drives the host-written level.
// RQ12: with host link lost, passthrough outputs are forced false.
// RQ13: after link restore, host passthrough writes are accepted again.
// RQ14: the state register encodes up to 32 states.
// RQ15: machine and compound each have one initial state.
// RQ16: a compound may be the initial state; entry descends into it.
// RQ17: the host keeps passthrough off safety-critical outputs.
// RQ18: each output has one writer; the innermost state decides it.
// RQ19: a flash output toggles at a configurable interval.
// RQ20: recovery time is a per-channel tick count, loaded then counted.
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`include "ssfr_cfg.svh"
module ssfr_top #(
	parameter int N_CH     = 4,
	parameter int N_VAR    = 2,
	parameter int RW       = 16,
	parameter int TICK_CYC = `SSFR_TICK_CYC
) (
	// clock and reset
	input  logic                   clk_i,
	input  logic                   rst_i,
	// wishbone slave
	input  ssfr_pkg::ssfr_wb_req_t wb_i,
	output logic [31:0]            wb_dat_o,
	output logic                   wb_ack_o,
	// field side pins
	input  logic [N_CH-1:0]        oc_pin_i,
	input  logic [N_CH-1:0]        digital_input_channel_i,
	input  logic                   field_supply_ok_i,
	input  logic                   host_link_ok_i,
	// channel outputs and status
	output logic [N_CH-1:0]        digital_output_channel_o,
	output logic [N_CH-1:0]        overcurrent_fault_flag_o,
	output logic                   failsafe_o
);
	localparam int NS = `SSFR_NSTATE;
	localparam int SW = `SSFR_SW;
	localparam int DEP = `SSFR_DEPTH;
	localparam int N_OUT = N_CH + N_VAR;
	localparam int EW = $bits(ssfr_pkg::ssfr_ent_t);
	localparam logic [11:0] REC_B = `SSFR_REC_BASE;
	localparam logic [11:0] TAB_B = `SSFR_TAB_BASE;

	if (N_CH < 1 || N_CH > 8 || N_OUT * 3 > 32 || RW < 1 || RW > 32)
	begin : g_chk
		$error("ssfr_top: unsupported channel or width parameters");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic                               ack;
		logic [31:0]                        rdat;
		logic                               run;
		logic [SW-1:0]                      init;
		logic                               act;
		logic [SW-1:0]                      cur;
		logic [N_CH-1:0][1:0]               ocm;
		logic [N_CH-1:0][RW-1:0]            rec;
		logic [N_OUT-1:0][1:0]              dflt;
		logic [N_CH-1:0]                    pt;
		logic [RW-1:0]                      fint;
		logic [N_OUT-1:0]                   out;
		logic [N_CH-1:0]                    dout;
		logic                               fs;
		ssfr_pkg::ssfr_ent_t [NS-1:0]       ent;
		logic [NS-1:0][N_OUT-1:0][2:0]      asg;
		logic [1:0][N_CH-1:0]               oc_s;
		logic [1:0][N_CH-1:0]               din_s;
		logic [1:0]                         sup_s;
		logic [1:0]                         lnk_s;
	} ssfr_st_t;
	ssfr_st_t q, d;

	logic                      tick;
	logic                      flash;
	logic [N_CH-1:0]           flt;
	logic [N_CH-1:0]           deen;
	logic [N_CH-1:0]           fsv;
	logic [DEP-1:0][SW-1:0]    anc;
	logic [DEP-1:0]            val;
	logic [N_OUT-1:0][1:0]     kwv;
	logic [N_OUT-1:0]          lvl;
	logic [N_OUT-1:0]          ptx;
	logic [15:0]               cv;
	logic [SW-1:0]             nxt;
	logic [SW-1:0]             tidx;
	logic [3:0]                ridx;
	logic                      acc;
	logic                      rec_hit;
	logic                      tab_hit;
	logic [31:0]               rd;
	logic [31:0]               wr;

	// byte lanes not selected keep the old register bits
	function automatic logic [31:0] byte_merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			byte_merge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
		end
	endfunction

	// ------------------------------------------------------------
	// tick divider and channel trip logic
	// ------------------------------------------------------------
	ssfr_tick #(
		.TICK_CYC (TICK_CYC),
		.FW       (RW)
	) u_tick (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.fint_i  (q.fint),
		.tick_o  (tick),
		.flash_o (flash)
	);

	for (genvar g = 0; g < N_CH; g++) begin : g_ch
		ssfr_chan #(
			.RW (RW)
		) u_chan (
			.clk_i    (clk_i),
			.rst_i    (rst_i),
			.tick_i   (tick),
			.oc_i     (q.oc_s[1][g]),
			.sup_ok_i (q.sup_s[1]),
			.mode_i   (ssfr_pkg::ssfr_ocm_t'(q.ocm[g])),
			.rec_i    (q.rec[g]),
			.fault_o  (flt[g]),
			.deen_o   (deen[g]),
			.fs_o     (fsv[g])
		);
	end

	// bus decode helpers and condition vector
	assign acc = wb_i.cyc && wb_i.stb && !q.ack;
	assign ridx = 4'(wb_i.adr >> `SSFR_WSH);
	assign tidx = SW'(wb_i.adr >> `SSFR_ESH);
	assign rec_hit = ((wb_i.adr & ~`SSFR_REC_MASK) == REC_B)
		&& (32'(ridx) < N_CH);
	assign tab_hit = (wb_i.adr & ~`SSFR_TAB_MASK) == TAB_B;
	assign ptx = N_OUT'(q.pt);
	assign cv = 16'({q.din_s[1], flt}); // see RQ6

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		// two-stage synchronisers for pins
		d.oc_s[1] = q.oc_s[0];
		d.oc_s[0] = oc_pin_i;
		d.din_s[1] = q.din_s[0];
		d.din_s[0] = digital_input_channel_i;
		d.sup_s[1] = q.sup_s[0];
		d.sup_s[0] = field_supply_ok_i;
		d.lnk_s[1] = q.lnk_s[0];
		d.lnk_s[0] = host_link_ok_i;
		d.fs = |fsv; // see RQ2

		// chain of enclosing states, innermost first
		anc[0] = q.cur;
		val[0] = q.act;
		for (int k = 1; k < DEP; k++) begin
			anc[k] = q.ent[anc[k-1]].parent;
			val[k] = val[k-1] && q.ent[anc[k-1]].par_en;
		end

		// resolve each output, inner assignments override outer
		for (int o = 0; o < N_OUT; o++) begin
			kwv[o] = q.dflt[o]; // see RQ7, RQ8
			for (int k = DEP - 1; k >= 0; k--) begin
				if (val[k] && q.asg[anc[k]][o][2]) begin
					kwv[o] = q.asg[anc[k]][o][1:0]; // see RQ9, RQ10, RQ18
				end
			end
			unique case (ssfr_pkg::ssfr_kw_t'(kwv[o]))
			ssfr_pkg::SSFR_KW_FALSE: lvl[o] = 1'b0;
			ssfr_pkg::SSFR_KW_TRUE: lvl[o] = 1'b1;
			ssfr_pkg::SSFR_KW_FLASH: lvl[o] = flash; // see RQ19
			ssfr_pkg::SSFR_KW_PASS: lvl[o] = q.lnk_s[1] && ptx[o]; // see RQ11
			endcase
		end
		d.out = lvl;
		// tripped channels and fail-safe override the resolved level
		d.dout = lvl[N_CH-1:0] & ~deen
			& {N_CH{q.sup_s[1] && !q.fs}}; // see RQ1, RQ4, RQ5

		// transitions, an enclosing compound's border wins
		nxt = q.cur;
		for (int k = 0; k < DEP; k++) begin
			if (val[k] && q.ent[anc[k]].tr_en && cv[q.ent[anc[k]].cond]) begin
				nxt = q.ent[anc[k]].target;
			end
		end
		if (q.run && !q.act) nxt = q.init; // see RQ15
		// descend through compound initial states
		for (int k = 0; k < DEP; k++) begin
			if (q.ent[nxt].cmp) nxt = q.ent[nxt].child; // see RQ16
		end
		d.act = q.run;
		if (q.run) d.cur = nxt; // see RQ14

		// passthrough levels drop while the host link is down
		if (!q.lnk_s[1]) d.pt = '0; // see RQ12

		// register read mux
		rd = '0;
		if (wb_i.adr == `SSFR_REG_CTRL) begin
			rd[`SSFR_CTRL_RUN] = q.run;
			rd[`SSFR_CTRL_INIT +: SW] = q.init;
		end else if (wb_i.adr == `SSFR_REG_STAT) begin
			rd[`SSFR_STAT_FS] = q.fs;
			rd[`SSFR_STAT_SUP] = q.sup_s[1];
			rd[`SSFR_STAT_LNK] = q.lnk_s[1];
			rd[`SSFR_STAT_ACT] = q.act;
			rd[`SSFR_STAT_CUR +: SW] = q.cur;
			rd[`SSFR_STAT_FLT +: N_CH] = flt; // see RQ6
		end else if (wb_i.adr == `SSFR_REG_OCM) begin
			rd[2*N_CH-1:0] = q.ocm;
		end else if (wb_i.adr == `SSFR_REG_DFLT) begin
			rd[2*N_OUT-1:0] = q.dflt;
		end else if (wb_i.adr == `SSFR_REG_PASS) begin
			rd[N_CH-1:0] = q.pt;
		end else if (wb_i.adr == `SSFR_REG_FINT) begin
			rd[RW-1:0] = q.fint;
		end else if (wb_i.adr == `SSFR_REG_OUTS) begin
			rd[N_OUT-1:0] = q.out;
		end else if (rec_hit) begin
			rd[RW-1:0] = q.rec[ridx];
		end else if (tab_hit) begin
			if (wb_i.adr[`SSFR_WSH]) rd[3*N_OUT-1:0] = q.asg[tidx];
			else rd[EW-1:0] = q.ent[tidx];
		end
		wr = byte_merge(rd, wb_i.dat, wb_i.sel);
		d.ack = acc;
		d.rdat = rd;

		// register writes
		if (acc && wb_i.we) begin
			if (wb_i.adr == `SSFR_REG_CTRL) begin
				d.run = wr[`SSFR_CTRL_RUN];
				d.init = wr[`SSFR_CTRL_INIT +: SW];
			end else if (wb_i.adr == `SSFR_REG_OCM) begin
				d.ocm = wr[2*N_CH-1:0];
			end else if (wb_i.adr == `SSFR_REG_DFLT) begin
				d.dflt = wr[2*N_OUT-1:0];
			end else if (wb_i.adr == `SSFR_REG_PASS) begin
				if (q.lnk_s[1]) d.pt = wr[N_CH-1:0]; // see RQ13
			end else if (wb_i.adr == `SSFR_REG_FINT) begin
				d.fint = wr[RW-1:0];
			end else if (rec_hit) begin
				d.rec[ridx] = wr[RW-1:0]; // see RQ20
			end else if (tab_hit) begin
				if (wb_i.adr[`SSFR_WSH]) d.asg[tidx] = wr[3*N_OUT-1:0];
				else d.ent[tidx] = ssfr_pkg::ssfr_ent_t'(wr[EW-1:0]);
			end
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) q <= '0;
		else q <= d;
	end

	// outputs
	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdat;
	assign digital_output_channel_o = q.dout;
	assign overcurrent_fault_flag_o = flt;
	assign failsafe_o = q.fs;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_fs_out;
		q.fs |=> digital_output_channel_o == '0;
	endproperty
	a_fs_out: assert property (p_fs_out) // see RQ2
		else $error("output energized in fail-safe");
	property p_oc_off;
		deen[0] |=> !digital_output_channel_o[0];
	endproperty
	a_oc_off: assert property (p_oc_off) // see RQ1
		else $error("tripped channel still energized");
	property p_pass_lost;
		!q.lnk_s[1] |=> q.pt == '0;
	endproperty
	a_pass_lost: assert property (p_pass_lost) // see RQ12
		else $error("passthrough level kept with link lost");
	// every output on passthrough follows the host level while stopped
	for (genvar o = 0; o < N_OUT; o++) begin : g_pass_chk
		property p_pass_drv;
			!q.act && q.dflt[o] == ssfr_pkg::SSFR_KW_PASS
				|=> q.out[o] == ($past(q.lnk_s[1]) && $past(ptx[o]));
		endproperty
		a_pass_drv: assert property (p_pass_drv) // see RQ11
			else $error("passthrough output not the host level");
	end
	property p_pass_wr;
		acc && wb_i.we && wb_i.adr == `SSFR_REG_PASS && wb_i.sel[0]
			&& q.lnk_s[1] |=> q.pt[0] == $past(wb_i.dat[0]);
	endproperty
	a_pass_wr: assert property (p_pass_wr) // see RQ13
		else $error("host passthrough write lost");
	property p_dflt;
		!q.act && q.dflt[0] == ssfr_pkg::SSFR_KW_TRUE |=> q.out[0];
	endproperty
	a_dflt: assert property (p_dflt) // see RQ7
		else $error("default level not applied before start");
	property p_unasg;
		q.act && !q.asg[q.cur][0][2] && !q.ent[q.cur].par_en
			&& !q.dflt[0][1] |=> q.out[0] == $past(q.dflt[0][0]);
	endproperty
	a_unasg: assert property (p_unasg) // see RQ8
		else $error("unassigned output not at default");
	property p_entry;
		$rose(q.act) |-> !q.ent[q.cur].cmp;
	endproperty
	a_entry: assert property (p_entry) // see RQ16
		else $error("execution began in a compound state");
	c_start: cover property ($rose(q.act));
	c_fs: cover property ($rose(q.fs));
	c_pass: cover property (q.lnk_s[1] && q.pt[0]
		&& digital_output_channel_o[0]);
endmodule

// file: test/ssfr_field_model.sv
// field wiring model: channel shorts, field supply and field inputs
`timescale 1ns/10ps
module ssfr_field_model #(
	parameter int N = 4
) (
	// clock
	input  wire logic         clk_i,
	// bench controls
	input  wire logic [N-1:0] short_i,
	input  wire logic         sup_on_i,
	// block side
	input  wire logic [N-1:0] dout_i,
	output logic      [N-1:0] oc_o = '0,
	output logic              sup_ok_o = 1'b0,
	output logic      [N-1:0] din_o = '0
);
	// a short draws current only while its channel is energized and fed
	always_ff @(posedge clk_i) begin
		oc_o     <= short_i & dout_i & {N{sup_on_i}};
		sup_ok_o <= sup_on_i;
		din_o    <= ~short_i;
	end
endmodule

// file: test/safety_output_fault_recovery_tb.sv
// self-checking testbench for the safety output recovery block
`timescale 1ns/10ps
module safety_output_fault_recovery_tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic                   clk_i = 1'b0;
	logic                   rst_i = 1'b1;
	ssfr_pkg::ssfr_wb_req_t wb_i = '0;
	logic [31:0]            wb_dat_o;
	logic                   wb_ack_o;
	logic [3:0]             oc, din, dout, flt;
	logic [3:0]             shrt = 4'h0;
	logic                   sup, fs, p;
	logic                   sup_on = 1'b1;
	logic                   link = 1'b1;
	logic [31:0]            r;
	int                     miscompares = 0;
	int                     n_checks = 0;
	int                     i, k;

	// 10 MHz clock
	always #50 clk_i = ~clk_i;

	ssfr_top #(.TICK_CYC(4)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.oc_pin_i(oc), .digital_input_channel_i(din),
		.field_supply_ok_i(sup), .host_link_ok_i(link),
		.digital_output_channel_o(dout),
		.overcurrent_fault_flag_o(flt), .failsafe_o(fs));

	ssfr_field_model fld (
		.clk_i(clk_i), .short_i(shrt), .sup_on_i(sup_on),
		.dout_i(dout), .oc_o(oc), .sup_ok_o(sup), .din_o(din));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task print_verdict;
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h, expected %h",
				$time, got, exp);
		end
	endtask

	// one classic cycle, held until ack is sampled high
	task wb(input logic we, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_i <= '{1'b1, 1'b1, we, a, 4'hF, d};
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_i <= '0;
		// ack stands for one cycle only
		@(posedge clk_i);
		chk({31'h0, wb_ack_o}, 32'h0000_0000);
	endtask

	task rc(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(r & m, e);
	endtask

	// wait a bounded time for a fault flag to reach a level
	task waitf(input int c, input logic v, input int lim);
		int n;
		n = 0;
		while (flt[c] !== v && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		chk({31'h0, flt[c]}, {31'h0, v});
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values and an unmapped place
		rc(12'h000, 32'hFFFF_FFFF, 32'h0000_0000);
		rc(12'h008, 32'hFFFF_FFFF, 32'h0000_0000);
		wb(1'b1, 12'h020, 32'hFFFF_FFFF);
		rc(12'h020, 32'hFFFF_FFFF, 32'h0000_0000);
		// defaults while stopped, ch2 on passthrough, ch3 flashing
		wb(1'b1, 12'h00C, 32'h0000_01B5);
		wb(1'b1, 12'h014, 32'h0000_0000);
		wb(1'b1, 12'h010, 32'h0000_0004);
		rc(12'h018, 32'h0000_0037, 32'h0000_0017);
		k = 0;
		p = dout[3];
		for (i = 0; i < 24; i++) begin
			@(posedge clk_i);
			if (dout[3] !== p) k++;
			p = dout[3];
		end
		chk({31'h0, k >= 3}, 32'h0000_0001);
		// link loss forces passthrough low and refuses host writes
		link <= 1'b0;
		repeat (4) @(posedge clk_i);
		rc(12'h018, 32'h0000_0037, 32'h0000_0013);
		wb(1'b1, 12'h010, 32'h0000_0004);
		rc(12'h018, 32'h0000_0037, 32'h0000_0013);
		link <= 1'b1;
		repeat (4) @(posedge clk_i);
		wb(1'b1, 12'h010, 32'h0000_0004);
		rc(12'h018, 32'h0000_0037, 32'h0000_0017);
		// state 0 leaves on ch1 fault to compound 1, child 2
		wb(1'b1, 12'h100, 32'h0000_0221);
		wb(1'b1, 12'h104, 32'h0000_4000);
		wb(1'b1, 12'h108, 32'h0020_0800);
		wb(1'b1, 12'h10C, 32'h0000_0004);
		wb(1'b1, 12'h110, 32'h0010_8000);
		wb(1'b1, 12'h114, 32'h0000_0000);
		wb(1'b1, 12'h008, 32'h0000_0009);
		wb(1'b1, 12'h040, 32'h0000_0002);
		wb(1'b1, 12'h000, 32'h0000_0001);
		rc(12'h004, 32'h0000_1F08, 32'h0000_0008);
		rc(12'h018, 32'h0000_0037, 32'h0000_0007);
		// auto recovery on ch0 under a lasting short
		shrt <= 4'h1;
		waitf(0, 1'b1, 20);
		@(posedge clk_i);
		chk({31'h0, dout[0]}, 32'h0000_0000);
		repeat (7) @(posedge clk_i);
		chk({31'h0, flt[0]}, 32'h0000_0001);
		waitf(0, 1'b0, 40);
		waitf(0, 1'b1, 20);
		shrt <= 4'h0;
		waitf(0, 1'b0, 40);
		repeat (30) @(posedge clk_i);
		chk({27'h0, fs, flt}, 32'h0000_0000);
		chk({31'h0, dout[0]}, 32'h0000_0001);
		// no recover on ch1, its fault taken as a transition
		shrt <= 4'h2;
		waitf(1, 1'b1, 20);
		shrt <= 4'h0;
		repeat (60) @(posedge clk_i);
		chk({30'h0, dout[1], flt[1]}, 32'h0000_0001);
		chk({31'h0, fs}, 32'h0000_0000);
		rc(12'h004, 32'h0000_1F00, 32'h0000_0200);
		rc(12'h018, 32'h0000_0037, 32'h0000_0016);
		// fail-safe option on ch3
		shrt <= 4'h8;
		repeat (40) @(posedge clk_i);
		shrt <= 4'h0;
		repeat (20) @(posedge clk_i);
		chk({31'h0, fs}, 32'h0000_0001);
		// a field supply cycle releases both latches
		sup_on <= 1'b0;
		repeat (6) @(posedge clk_i);
		sup_on <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk({30'h0, fs, flt[1]}, 32'h0000_0000);
		// restart in simple state 0, then in compound state 1
		wb(1'b1, 12'h000, 32'h0000_0000);
		wb(1'b1, 12'h000, 32'h0000_0001);
		rc(12'h004, 32'h0000_1F08, 32'h0000_0008);
		wb(1'b1, 12'h000, 32'h0000_0000);
		wb(1'b1, 12'h000, 32'h0000_0101);
		rc(12'h004, 32'h0000_1F08, 32'h0000_0208);
		print_verdict;
	end

	// watchdog: the tests need well under a thousand cycles
	initial begin
		#(100 * 5000);
		miscompares++;
		print_verdict;
	end
endmodule
